// *** hdl/sbm_consts.svh ***
`ifndef SBM_CONSTS_SVH
`define SBM_CONSTS_SVH
`define SBM_ADDR_W      16
`define SBM_ROM_TOP     16'h07FF
`define SBM_ADDR_RST    16'h0000
`define SBM_BYTE_RST    8'h00
`define SBM_DP_ALL      6'h3F
`define SBM_DP_ADDR     6'h3C
`define SBM_DP_DATA     6'h03
`define SBM_DIGIT_F     7'h71
`define SBM_DIGIT_OFF   7'h00
`endif

// *** hdl/sbm_pkg.sv ***
package sbm_pkg;
  typedef logic [15:0] sbm_addr_t;
  typedef logic [7:0]  sbm_byte_t;
  typedef enum logic [1:0] {SBM_RUN, SBM_FINISH, SBM_HALTED} sbm_state_e;
  typedef enum logic [1:0] {SBM_VIEW_ADDR, SBM_VIEW_DATA, SBM_VIEW_CLEARED} sbm_view_e;
endpackage : sbm_pkg

// *** hdl/sbm_fetch_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface sbm_fetch_if;
  logic [15:0] addr;
  logic [7:0]  data;
  logic        valid;
  logic        first;
  logic        hit;
  modport src (output addr, output data, output valid, output first, input hit);
  modport cmp (input addr, input data, input valid, input first, output hit);
endinterface : sbm_fetch_if
`default_nettype wire

// *** hdl/sbm_match.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sbm_consts.svh"
module sbm_match
(
  sbm_fetch_if.cmp        fetch,
  input  wire logic       armed,
  input  wire logic [15:0] stop_addr
);
  import sbm_pkg::*;
  // Operand fetches carry first low, so they never match
  assign fetch.hit = armed && fetch.valid && fetch.first && (fetch.addr == stop_addr);
endmodule : sbm_match
`default_nettype wire

// *** hdl/sbm_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sbm_consts.svh"
module sbm_top
(
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  input  wire sbm_pkg::sbm_addr_t  fetch_addr,
  input  wire sbm_pkg::sbm_byte_t  fetch_data,
  input  wire logic                fetch_valid,
  input  wire logic                fetch_first,
  input  wire logic                arm_stop_key,
  input  wire logic                disarm_stop_key,
  input  wire logic                step_key,
  input  wire logic                run_key,
  input  wire logic                data_view,
  input  wire sbm_pkg::sbm_addr_t  view_addr,
  input  wire sbm_pkg::sbm_byte_t  view_data,
  output logic                     cpu_hold,
  output logic                     step_once,
  output logic                     reg_edit_en,
  output logic                     armed,
  output sbm_pkg::sbm_addr_t       stop_addr,
  output sbm_pkg::sbm_addr_t       shown_addr,
  output sbm_pkg::sbm_byte_t       shown_opcode,
  output logic [5:0]               dp_on,
  output logic                     show_cleared,
  output logic [6:0]               digit_seg
);
  import sbm_pkg::*;

  sbm_fetch_if fetch ();
  sbm_state_e  state;
  sbm_state_e  next_state;
  logic        arm_ok;
  logic        view_is_stop;
  logic        do_disarm;
  logic        resume;

  assign fetch.addr  = fetch_addr;
  assign fetch.data  = fetch_data;
  assign fetch.valid = fetch_valid;
  assign fetch.first = fetch_first;

  sbm_match u_match
  (
    .fetch     (fetch),
    .armed     (armed),
    .stop_addr (stop_addr)
  );

  assign arm_ok       = arm_stop_key && (view_addr > `SBM_ROM_TOP);
  assign view_is_stop = armed && (view_addr == stop_addr);
  assign do_disarm    = disarm_stop_key && view_is_stop && !arm_ok;
  assign resume       = (state == SBM_HALTED) && (step_key || run_key);

  // Single register replaces older address; arm wins over a same-cycle disarm
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      armed     <= 1'b0;
      stop_addr <= `SBM_ADDR_RST;
    end
    else if (arm_ok)
    begin
      armed     <= 1'b1;
      stop_addr <= view_addr;
    end
    else if (do_disarm)
    begin
      armed <= 1'b0;
    end
  end

  // Hit waits for the next opcode fetch, so the stopped instruction has finished
  always_comb
  begin
    next_state = state;
    case (state)
      SBM_RUN:    if (fetch.hit) next_state = SBM_FINISH;
      SBM_FINISH: if (fetch_valid && fetch_first) next_state = SBM_HALTED;
      SBM_HALTED: if (resume) next_state = SBM_RUN;
      default:    next_state = SBM_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= SBM_RUN;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Capture the next instruction's address and opcode at suspension
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shown_addr   <= `SBM_ADDR_RST;
      shown_opcode <= `SBM_BYTE_RST;
    end
    else if (state == SBM_FINISH && fetch.valid && fetch.first)
    begin
      shown_addr   <= fetch.addr;
      shown_opcode <= fetch.data;
    end
  end

  // Cleared pattern holds until another key is pressed
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      show_cleared <= 1'b0;
    end
    else if (do_disarm)
    begin
      show_cleared <= 1'b1;
    end
    else if (arm_stop_key || step_key || run_key || disarm_stop_key)
    begin
      show_cleared <= 1'b0;
    end
  end

  // Hold is raised on the fetch that proves the instruction done
  assign cpu_hold    = (state == SBM_HALTED) ||
                       (state == SBM_FINISH && fetch_valid && fetch_first);
  assign step_once   = (state == SBM_HALTED) && step_key;
  assign reg_edit_en = (state == SBM_HALTED);

  always_comb
  begin
    if (show_cleared)
      dp_on = `SBM_DP_ALL;
    else if (view_is_stop)
      dp_on = `SBM_DP_ALL;
    else if (data_view)
      dp_on = `SBM_DP_DATA;
    else
      dp_on = `SBM_DP_ADDR;
  end

  assign digit_seg = show_cleared ? `SBM_DIGIT_F : `SBM_DIGIT_OFF;

  a_single_stop: assert property (@(posedge sys_clk) disable iff (!reset_n)
    arm_ok |=> armed && stop_addr == $past(view_addr))
    else $error("armed address not replaced");
  a_rom_refused: assert property (@(posedge sys_clk) disable iff (!reset_n)
    arm_stop_key && view_addr <= `SBM_ROM_TOP |=> $stable(stop_addr))
    else $error("armed in read-only region");
  a_operand_ignored: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state == SBM_RUN && fetch_valid && !fetch_first |=> state == SBM_RUN)
    else $error("operand fetch triggered a stop");
  sequence s_hit;
    state == SBM_RUN && fetch.hit;
  endsequence
  // A one-byte instruction is already done by the very next opcode fetch
  a_finish_first: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_hit |=> state == SBM_FINISH && (!cpu_hold || (fetch_valid && fetch_first)))
    else $error("suspended before instruction finished");
  a_saved_pc: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state == SBM_FINISH && fetch_valid && fetch_first |=>
      state == SBM_HALTED && shown_addr == $past(fetch_addr) &&
      shown_opcode == $past(fetch_data))
    else $error("saved address wrong");
  a_resume_run: assert property (@(posedge sys_clk) disable iff (!reset_n)
    resume |=> state == SBM_RUN)
    else $error("did not resume");
  a_stays_armed: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state == SBM_HALTED && armed && !disarm_stop_key |=> armed)
    else $error("stop address lost after hit");
  a_all_dots: assert property (@(posedge sys_clk) disable iff (!reset_n)
    view_is_stop |-> dp_on == `SBM_DP_ALL)
    else $error("dots wrong on stop address");
  a_disarm_shows: assert property (@(posedge sys_clk) disable iff (!reset_n)
    do_disarm |=> !armed && show_cleared && digit_seg == `SBM_DIGIT_F)
    else $error("disarm not confirmed");
  sequence s_done;
    state == SBM_FINISH && fetch_valid && fetch_first;
  endsequence
  a_hit_stops: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state == SBM_RUN && armed && fetch_valid && fetch_first && fetch_addr == stop_addr |=>
      state == SBM_FINISH)
    else $error("opcode fetch at stop address ignored");
  a_no_stray_stop: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state == SBM_RUN && !(armed && fetch_addr == stop_addr) |=> state == SBM_RUN)
    else $error("stop on an address that is not armed");
  a_edit_open: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_done |=> reg_edit_en && cpu_hold)
    else $error("register edit not opened at suspension");
  a_run_closed: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state == SBM_RUN |-> !reg_edit_en && !cpu_hold && !step_once)
    else $error("edit or hold while running");
  a_step_resumes: assert property (@(posedge sys_clk) disable iff (!reset_n)
    step_once |=> state == SBM_RUN && !cpu_hold)
    else $error("step did not resume");
  a_four_dots: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !show_cleared && !data_view && !(armed && view_addr == stop_addr) |->
      dp_on == `SBM_DP_ADDR)
    else $error("address mode dots wrong");
  a_data_dots: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !show_cleared && data_view && !(armed && view_addr == stop_addr) |->
      dp_on == `SBM_DP_DATA)
    else $error("data mode dots wrong");
  a_cleared_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    show_cleared |-> dp_on == `SBM_DP_ALL && digit_seg == `SBM_DIGIT_F)
    else $error("cleared pattern wrong");
  a_key_clears: assert property (@(posedge sys_clk) disable iff (!reset_n)
    show_cleared && !do_disarm && (arm_stop_key || step_key || run_key) |=> !show_cleared)
    else $error("cleared pattern not dropped on key");
endmodule : sbm_top
`default_nettype wire

// *** bench/sbm_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module sbm_cpu_model
(
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  input  wire logic          cpu_hold,
  output sbm_pkg::sbm_addr_t addr,
  output sbm_pkg::sbm_byte_t data,
  output logic               valid,
  output logic               first
);
  import sbm_pkg::*;
  localparam logic [79:0] CODE  = 80'h3E00472FD3FF3D0418FA;
  localparam logic [9:0]  FIRST = 10'h2EE;
  logic [3:0] pc;
  assign addr  = 16'h1800 + {12'h000, pc};
  assign data  = CODE[79 - 8 * pc -: 8];
  assign first = FIRST[9 - pc];
  assign valid = reset_n;
  // Loop body 1804..1809 repeats forever, so a hit recurs on every pass
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      pc <= 4'h0;
    else if (!cpu_hold)
      pc <= (pc == 4'h9) ? 4'h4 : pc + 4'h1;
endmodule : sbm_cpu_model
`default_nettype wire

// *** bench/single_breakpoint_monitor_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "sbm_consts.svh"
module single_breakpoint_monitor_bench;
  import sbm_pkg::*;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [3:0] keys = 4'h0;
  logic       data_view = 1'b0;
  sbm_addr_t  view_addr = 16'h0000;
  sbm_addr_t  f_addr, stop_addr, shown_addr;
  sbm_byte_t  f_data, shown_opcode;
  logic       f_valid, f_first, cpu_hold, step_once, reg_edit_en, armed, show_cleared;
  logic [5:0] dp_on;
  logic [6:0] digit_seg;
  int         err_count = 0;
  int         total_checks = 0;
  int         seed = 34548;
  int         cnt;
  sbm_addr_t  ra;
  sbm_addr_t  exp_stop = 16'h0000;
  logic       rdv;
  logic       exp_on = 1'b0;
  always #2 sys_clk = ~sys_clk;
  sbm_cpu_model i_sbm_cpu_model (.sys_clk(sys_clk), .reset_n(reset_n), .cpu_hold(cpu_hold),
    .addr(f_addr), .data(f_data), .valid(f_valid), .first(f_first));
  sbm_top i_sbm_top (.sys_clk(sys_clk), .reset_n(reset_n), .fetch_addr(f_addr),
    .fetch_data(f_data), .fetch_valid(f_valid), .fetch_first(f_first),
    .arm_stop_key(keys[0]), .disarm_stop_key(keys[1]), .step_key(keys[2]),
    .run_key(keys[3]), .data_view(data_view), .view_addr(view_addr), .view_data(f_data),
    .cpu_hold(cpu_hold), .step_once(step_once), .reg_edit_en(reg_edit_en), .armed(armed),
    .stop_addr(stop_addr), .shown_addr(shown_addr), .shown_opcode(shown_opcode),
    .dp_on(dp_on), .show_cleared(show_cleared), .digit_seg(digit_seg));
  task automatic test_done;
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : chk
  // One-cycle key pulse together with the displayed address and mode
  task automatic key(input logic [3:0] k, input sbm_addr_t a, input logic dv);
    @(posedge sys_clk);
    keys <= k;
    view_addr <= a;
    data_view <= dv;
    @(posedge sys_clk);
    keys <= 4'h0;
    #1;
  endtask : key
  // Arming is legal only above the read-only region
  function automatic logic exp_arm(input sbm_addr_t a);
    return a > `SBM_ROM_TOP;
  endfunction : exp_arm
  // Stop address outranks the view mode; the cleared pattern is checked apart
  function automatic logic [5:0] exp_dots(input logic on_stop, input logic dv);
    if (on_stop)
      return `SBM_DP_ALL;
    else if (dv)
      return `SBM_DP_DATA;
    return `SBM_DP_ADDR;
  endfunction : exp_dots
  task automatic halt;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (cpu_hold === 1'b1) break;
    end
    @(posedge sys_clk);
    #1;
    chk("reg_edit_en", 16'h0001, {15'h0000, reg_edit_en});
    chk("shown_addr", 16'h1806, shown_addr);
    chk("shown_opcode", 16'h003D, {8'h00, shown_opcode});
  endtask : halt
  initial
  begin
    #20000;
    err_count++;
    test_done();
  end
  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1;
    chk("armed", 16'h0000, {15'h0000, armed});
    chk("dp_on", 16'h003C, {10'h000, dp_on});
    key(4'h1, 16'($random(seed)) & 16'h07FF, 1'b0);
    chk("armed", 16'h0000, {15'h0000, armed});
    // Addresses stay below the running program so no stop fires here
    for (int i = 0; i < 10; i++)
    begin
      ra = (i == 0) ? 16'h07FF : (i == 1) ? 16'h0800 : 16'($random(seed)) & 16'h0FFF;
      rdv = 1'($random(seed));
      key(4'h1, ra, rdv);
      if (exp_arm(ra))
      begin
        exp_on = 1'b1;
        exp_stop = ra;
      end
      chk("armed", {15'h0000, exp_on}, {15'h0000, armed});
      chk("stop_addr", exp_stop, stop_addr);
      chk("dp_on", {10'h000, exp_dots(exp_on && ra == exp_stop, rdv)}, {10'h000, dp_on});
    end
    key(4'h1, 16'h1804, 1'b0);
    chk("stop_addr", 16'h1804, stop_addr);
    chk("dp_on", 16'h003F, {10'h000, dp_on});
    halt();
    key(4'h8, 16'h1806, 1'b0);
    chk("cpu_hold", 16'h0000, {15'h0000, cpu_hold});
    chk("reg_edit_en", 16'h0000, {15'h0000, reg_edit_en});
    halt();
    @(posedge sys_clk);
    keys <= 4'h4;
    #1;
    chk("step_once", 16'h0001, {15'h0000, step_once});
    @(posedge sys_clk);
    keys <= 4'h0;
    #1;
    chk("step_once", 16'h0000, {15'h0000, step_once});
    halt();
    key(4'h1, 16'h1805, 1'b0);
    chk("stop_addr", 16'h1805, stop_addr);
    key(4'h8, 16'h1806, 1'b1);
    chk("dp_on", 16'h0003, {10'h000, dp_on});
    cnt = 0;
    repeat (40)
    begin
      @(posedge sys_clk);
      #1;
      if (cpu_hold !== 1'b0) cnt++;
    end
    chk("hold_count", 16'h0000, 16'(cnt));
    key(4'h2, 16'h1804, 1'b0);
    chk("armed", 16'h0001, {15'h0000, armed});
    chk("dp_on", 16'h003C, {10'h000, dp_on});
    key(4'h2, 16'h1805, 1'b0);
    chk("armed", 16'h0000, {15'h0000, armed});
    chk("digit_seg", 16'h0071, {9'h000, digit_seg});
    chk("show_cleared", 16'h0001, {15'h0000, show_cleared});
    chk("dp_on", 16'h003F, {10'h000, dp_on});
    // Any key drops the cleared pattern; address 1804, with nothing armed, now shows four dots
    key(4'h8, 16'h1804, 1'b0);
    chk("show_cleared", 16'h0000, {15'h0000, show_cleared});
    chk("digit_seg", 16'h0000, {9'h000, digit_seg});
    chk("dp_on", 16'h003C, {10'h000, dp_on});
    key(4'h1, 16'h1804, 1'b0);
    halt();
    // Reset in mid-run while suspended
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("armed", 16'h0000, {15'h0000, armed});
    chk("stop_addr", 16'h0000, stop_addr);
    chk("cpu_hold", 16'h0000, {15'h0000, cpu_hold});
    chk("reg_edit_en", 16'h0000, {15'h0000, reg_edit_en});
    @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("armed", 16'h0000, {15'h0000, armed});
    chk("cpu_hold", 16'h0000, {15'h0000, cpu_hold});
    test_done();
  end
endmodule : single_breakpoint_monitor_bench
`default_nettype wire
